//--- rtl/timer16_map.svh
// Register indices, field positions and fixed values of the 16-bit timer
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
`define IDX_CTRL_B      10'h02E
`define IDX_CTRL_A      10'h02F
`define IDX_COUNTER     10'h030
`define IDX_CMP_A       10'h031
`define IDX_CMP_B       10'h032
`define IDX_CAPTURE     10'h033
`define IDX_IRQ_STATUS  10'h034
`define IDX_IRQ_MASK    10'h035
`define IDX_PORT_DIR    10'h036
`define IDX_PORT_DATA   10'h037
`define CTRL_RESET      8'h00
`define WORD_RESET      16'h0000
`define CTRL_A_WMASK    8'hF3
`define CTRL_B_WMASK    8'hDF
`define COM_A_HI        7
`define COM_A_LO        6
`define COM_B_HI        5
`define COM_B_LO        4
`define WGM_LO_HI       1
`define WGM_LO_LO       0
`define WGM_HI_HI       4
`define WGM_HI_LO       3
`define WGM_TOP_BIT     4
`define CS_HI           2
`define CS_LO           0
`define ST_OVF          0
`define ST_CMP_A        1
`define ST_CMP_B        2
`define BOTTOM          16'h0000
`define MAX             16'hFFFF
`define TOP_8           16'h00FF
`define TOP_9           16'h01FF
`define TOP_10          16'h03FF
`define MODE_NORMAL     4'h0
`define MODE_PC8        4'h1
`define MODE_PC9        4'h2
`define MODE_PC10       4'h3
`define MODE_CTC_A      4'h4
`define MODE_FAST8      4'h5
`define MODE_FAST9      4'h6
`define MODE_FAST10     4'h7
`define MODE_PFC_CAP    4'h8
`define MODE_PFC_A      4'h9
`define MODE_PC_CAP     4'hA
`define MODE_PC_A       4'hB
`define MODE_CTC_CAP    4'hC
`define MODE_FAST_CAP   4'hE
`define MODE_FAST_A     4'hF
`define CS_STOP         3'h0
`define CS_DIV1         3'h1
`define CS_DIV8         3'h2
`define CS_DIV64        3'h3
`define CS_DIV256       3'h4
`define CS_DIV1024      3'h5
`define CS_EXT_FALL     3'h6
`define CS_EXT_RISE     3'h7
`define PRE_BITS_8      3
`define PRE_BITS_64     6
`define PRE_BITS_256    8
`define PRE_BITS_1024   10
`define COM_OFF         2'h0
`define COM_TOGGLE      2'h1
`endif

//--- rtl/timer16_pkg.sv
// Types shared by the 16-bit timer modules
package timer16_pkg;
  typedef enum logic [2:0] {
    cls_normal,
    cls_ctc,
    cls_fast,
    cls_pc,
    cls_pfc
  } wave_class_e;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] cnt;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b_buf;
    logic [15:0] cmp_b;
    logic [15:0] capture;
    logic        count_down;
    logic        block_match;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [1:0]  port_dir;
    logic [1:0]  port_data;
    logic [1:0]  wave;
    logic [1:0]  pin_out;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } timer_state_s;
endpackage : timer16_pkg

//--- rtl/tick_prescaler.sv
// Tick source: I/O clock divider and synchronised external edge pin
`timescale 1ns/10ps
`include "timer16_map.svh"
module tick_prescaler #(
  parameter int DIV_W = 10
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] sel,
  input  wire logic       ext_pin,
  output logic            tick
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [2:0]       sync;
  } presc_state_s;

  presc_state_s st;
  presc_state_s next_st;

  if (DIV_W < `PRE_BITS_1024) begin : g_chk
    $error("tick_prescaler: DIV_W too small for the largest divider");
  end

  always_comb begin
    next_st = st;
    next_st.div = st.div + DIV_W'(1);
    // Stage 0 feeds only stage 1; edges are seen between stages 1 and 2
    next_st.sync = {st.sync[1], st.sync[0], ext_pin};
    unique case (sel)
      `CS_STOP:     tick = 1'b0;
      `CS_DIV1:     tick = 1'b1;
      `CS_DIV8:     tick = &st.div[`PRE_BITS_8-1:0];
      `CS_DIV64:    tick = &st.div[`PRE_BITS_64-1:0];
      `CS_DIV256:   tick = &st.div[`PRE_BITS_256-1:0];
      `CS_DIV1024:  tick = &st.div[`PRE_BITS_1024-1:0];
      `CS_EXT_FALL: tick = st.sync[2] & ~st.sync[1];
      `CS_EXT_RISE: tick = ~st.sync[2] & st.sync[1];
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : tick_prescaler

//--- rtl/compare_channel.sv
// Output-compare waveform action for one channel
`timescale 1ns/10ps
`include "timer16_map.svh"
module compare_channel
  import timer16_pkg::*;
#(
  parameter bit CHAN_A = 1'b1
) (
  input  wire wave_class_e cls,
  input  wire logic [1:0]  com,
  input  wire logic        wgm_top,
  input  wire logic        match,
  input  wire logic        at_bottom,
  input  wire logic        count_down,
  input  wire logic        cmp_is_top,
  input  wire logic        wave,
  output logic             next_wave,
  output logic             override
);
  logic pwm;
  logic toggle_ok;
  logic lvl;

  always_comb begin
    pwm = (cls == cls_fast) || (cls == cls_pc) || (cls == cls_pfc);
    toggle_ok = !pwm || (wgm_top && CHAN_A);
    lvl = com[0];
    override = (com != `COM_OFF) &&
               !((com == `COM_TOGGLE) && !toggle_ok);
    next_wave = wave;
    if (com == `COM_TOGGLE) begin
      if (match && toggle_ok) begin
        next_wave = ~wave;
      end
    end else if (com != `COM_OFF) begin
      if (!pwm) begin
        if (match) begin
          next_wave = lvl;
        end
      end else if (cls == cls_fast) begin
        if (at_bottom) begin
          next_wave = ~lvl;
        end
        // A match at TOP is ignored; only BOTTOM acts then
        if (match && !cmp_is_top) begin
          next_wave = lvl;
        end
      end else if (match) begin
        next_wave = count_down ? ~lvl : lvl;
      end
    end
  end
endmodule : compare_channel

//--- rtl/timer16_waveform_mode_control.sv
// 16-bit timer waveform mode control with APB registers
// Overview of operation
// - Counter is synchronous to clk; the tick only qualifies counting.
// - Modes 8 and 9 load compare buffers and set overflow at BOTTOM.
// - Nonzero output mode, save a disconnected PWM 01, hands the pin to the wave; direction enables driver.
// - Non-PWM modes: 00 off, 01 toggle, 10 low, 11 high on match.
// - Fast PWM: 10 clears on match, sets at BOTTOM; 11 the inverse.
// - PWM mode 01 is disconnected unless top mode bit set; then A toggles.
// - Fast PWM 10/11 with compare equal TOP ignores match, acts at BOTTOM only.
// - Dual-slope: 10 clears on up match, sets on down match; 11 inverse.
// - Four-bit waveform mode: low bits in control A, high in control B.
// - Modes 0, 4, 12: free or clear on match, immediate update, flag at MAX.
// - Phase correct 1,2,3,10,11: update at TOP, overflow at BOTTOM.
// - Fast PWM 5,6,7,14,15: update at BOTTOM, overflow at TOP.
// - BOTTOM events use the same cycle timing as TOP events.
// - Clock select: stop, divide by 1..1024, or external falling/rising.
`timescale 1ns/10ps
`include "timer16_map.svh"
module timer16_waveform_mode_control
  import timer16_pkg::*;
#(
  parameter int APB_ADDR_W = 12,
  parameter int DIV_W      = 10
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  ext_tick_pin,
  output logic                       pin_a_out,
  output logic                       pin_a_oe,
  output logic                       pin_b_out,
  output logic                       pin_b_oe,
  output logic                       irq
);
  if (APB_ADDR_W < 12 || APB_ADDR_W > 32) begin : g_chk
    $error("timer16: APB_ADDR_W must be 12 to 32");
  end

  timer_state_s st;
  timer_state_s next_st;

  logic [3:0]  waveform_mode_select;
  wave_class_e cls;
  logic [15:0] top;
  logic        tick;
  logic        at_top;
  logic        at_bottom;
  logic        at_max;
  logic        match_a;
  logic        match_b;
  logic        wave_a_next;
  logic        wave_b_next;
  logic        ovr_a;
  logic        ovr_b;
  logic [9:0]  idx;
  logic        mapped;
  logic        wr;
  logic        cnt_wr;
  logic [31:0] rdata;
  logic [1:0]  out_mode_chan_a;
  logic [1:0]  out_mode_chan_b;

  assign waveform_mode_select = {st.ctrl_b[`WGM_HI_HI:`WGM_HI_LO],
                                 st.ctrl_a[`WGM_LO_HI:`WGM_LO_LO]};
  assign out_mode_chan_a = st.ctrl_a[`COM_A_HI:`COM_A_LO];
  assign out_mode_chan_b = st.ctrl_a[`COM_B_HI:`COM_B_LO];

  // Mode 13 decodes as normal counting so a stray write cannot hang it
  always_comb begin
    cls = cls_normal;
    top = `MAX;
    unique case (waveform_mode_select)
      `MODE_NORMAL:   begin cls = cls_normal; top = `MAX;       end
      `MODE_CTC_A:    begin cls = cls_ctc;    top = st.cmp_a;   end
      `MODE_CTC_CAP:  begin cls = cls_ctc;    top = st.capture; end
      `MODE_PC8:      begin cls = cls_pc;     top = `TOP_8;     end
      `MODE_PC9:      begin cls = cls_pc;     top = `TOP_9;     end
      `MODE_PC10:     begin cls = cls_pc;     top = `TOP_10;    end
      `MODE_PC_CAP:   begin cls = cls_pc;     top = st.capture; end
      `MODE_PC_A:     begin cls = cls_pc;     top = st.cmp_a;   end
      `MODE_FAST8:    begin cls = cls_fast;   top = `TOP_8;     end
      `MODE_FAST9:    begin cls = cls_fast;   top = `TOP_9;     end
      `MODE_FAST10:   begin cls = cls_fast;   top = `TOP_10;    end
      `MODE_FAST_CAP: begin cls = cls_fast;   top = st.capture; end
      `MODE_FAST_A:   begin cls = cls_fast;   top = st.cmp_a;   end
      `MODE_PFC_CAP:  begin cls = cls_pfc;    top = st.capture; end
      `MODE_PFC_A:    begin cls = cls_pfc;    top = st.cmp_a;   end
      default:        begin cls = cls_normal; top = `MAX;       end
    endcase
  end

  tick_prescaler #(
    .DIV_W (DIV_W)
  ) u_presc (
    .clk     (clk),
    .rst_b   (rst_b),
    .sel     (st.ctrl_b[`CS_HI:`CS_LO]),
    .ext_pin (ext_tick_pin),
    .tick    (tick)
  );

  // Tick is an enable on clk, never a clock of its own
  assign at_top    = tick && (st.cnt == top);
  assign at_bottom = tick && (st.cnt == `BOTTOM);
  assign at_max    = tick && (st.cnt == `MAX);
  assign match_a   = tick && !st.block_match && (st.cnt == st.cmp_a);
  assign match_b   = tick && !st.block_match && (st.cnt == st.cmp_b);

  compare_channel #(
    .CHAN_A (1'b1)
  ) u_chan_a (
    .cls        (cls),
    .com        (out_mode_chan_a),
    .wgm_top    (waveform_mode_select[`WGM_TOP_BIT-1]),
    .match      (match_a),
    .at_bottom  (at_bottom),
    .count_down (st.count_down),
    .cmp_is_top (st.cmp_a == top),
    .wave       (st.wave[0]),
    .next_wave  (wave_a_next),
    .override   (ovr_a)
  );

  compare_channel #(
    .CHAN_A (1'b0)
  ) u_chan_b (
    .cls        (cls),
    .com        (out_mode_chan_b),
    .wgm_top    (waveform_mode_select[`WGM_TOP_BIT-1]),
    .match      (match_b),
    .at_bottom  (at_bottom),
    .count_down (st.count_down),
    .cmp_is_top (st.cmp_b == top),
    .wave       (st.wave[1]),
    .next_wave  (wave_b_next),
    .override   (ovr_b)
  );

  // Upper address bits above the 4 KiB window are not decoded
  assign idx = paddr[11:2];
  assign wr  = psel && penable && st.pready && pwrite && mapped;
  assign cnt_wr = wr && (idx == `IDX_COUNTER);

  always_comb begin
    mapped = 1'b1;
    rdata  = '0;
    unique case (idx)
      `IDX_CTRL_A:     rdata[7:0]  = st.ctrl_a;
      `IDX_CTRL_B:     rdata[7:0]  = st.ctrl_b;
      `IDX_COUNTER:    rdata[15:0] = st.cnt;
      `IDX_CMP_A:      rdata[15:0] = st.cmp_a_buf;
      `IDX_CMP_B:      rdata[15:0] = st.cmp_b_buf;
      `IDX_CAPTURE:    rdata[15:0] = st.capture;
      `IDX_IRQ_STATUS: rdata[2:0]  = st.status;
      `IDX_IRQ_MASK:   rdata[2:0]  = st.mask;
      `IDX_PORT_DIR:   rdata[1:0]  = st.port_dir;
      `IDX_PORT_DATA:  rdata[1:0]  = st.port_data;
      default:         mapped      = 1'b0;
    endcase
  end

  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  sb);
    logic [15:0] v;
    v = old;
    if (sb[0]) v[7:0]  = wd[7:0];
    if (sb[1]) v[15:8] = wd[15:8];
    return v;
  endfunction : lane16

  always_comb begin
    logic immediate;
    logic load;
    logic [2:0] set;
    logic [2:0] clr;
    immediate = (cls == cls_normal) || (cls == cls_ctc);
    load = (cls == cls_pc) ? at_top : at_bottom;
    set = '0;
    clr = '0;
    next_st = st;

    // Counting sequence, advanced only on a tick
    if (tick) begin
      next_st.block_match = 1'b0;
      if ((cls == cls_pc) || (cls == cls_pfc)) begin
        if (!st.count_down) begin
          if (st.cnt >= top) begin
            next_st.count_down = 1'b1;
            next_st.cnt = st.cnt - 16'h0001;
          end else begin
            next_st.cnt = st.cnt + 16'h0001;
          end
        end else if (st.cnt == `BOTTOM) begin
          next_st.count_down = 1'b0;
          next_st.cnt = st.cnt + 16'h0001;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end else begin
        next_st.count_down = 1'b0;
        next_st.cnt = at_top ? `BOTTOM : st.cnt + 16'h0001;
      end
    end

    // Overflow flag point per mode
    unique case (cls)
      cls_normal, cls_ctc: set[`ST_OVF] = at_max;
      cls_fast:            set[`ST_OVF] = at_top;
      default:             set[`ST_OVF] = at_bottom;
    endcase
    set[`ST_CMP_A] = match_a;
    set[`ST_CMP_B] = match_b;

    // Double-buffered compare load
    if (!immediate && load) begin
      next_st.cmp_a = st.cmp_a_buf;
      next_st.cmp_b = st.cmp_b_buf;
    end else if (immediate) begin
      next_st.cmp_a = st.cmp_a_buf;
      next_st.cmp_b = st.cmp_b_buf;
    end

    next_st.wave = {wave_b_next, wave_a_next};
    next_st.pin_out[0] = ovr_a ? st.wave[0] : st.port_data[0];
    next_st.pin_out[1] = ovr_b ? st.wave[1] : st.port_data[1];

    // APB: one wait cycle, write applied on the completing edge
    if (psel && penable && !st.pready) begin
      next_st.pready  = 1'b1;
      next_st.prdata  = rdata;
      next_st.pslverr = !mapped;
    end else begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end

    if (wr) begin
      unique case (idx)
        `IDX_CTRL_A: if (pstrb[0]) next_st.ctrl_a = pwdata[7:0] &
                                                    `CTRL_A_WMASK;
        `IDX_CTRL_B: if (pstrb[0]) next_st.ctrl_b = pwdata[7:0] &
                                                    `CTRL_B_WMASK;
        `IDX_COUNTER: begin
          // Writing the counter blocks the match on the next tick
          next_st.cnt = lane16(st.cnt, pwdata, pstrb);
          next_st.block_match = 1'b1;
        end
        `IDX_CMP_A: begin
          next_st.cmp_a_buf = lane16(st.cmp_a_buf, pwdata, pstrb);
          if (immediate) next_st.cmp_a = next_st.cmp_a_buf;
        end
        `IDX_CMP_B: begin
          next_st.cmp_b_buf = lane16(st.cmp_b_buf, pwdata, pstrb);
          if (immediate) next_st.cmp_b = next_st.cmp_b_buf;
        end
        `IDX_CAPTURE: next_st.capture = lane16(st.capture, pwdata, pstrb);
        `IDX_IRQ_STATUS: if (pstrb[0]) clr = pwdata[2:0];
        `IDX_IRQ_MASK:   if (pstrb[0]) next_st.mask = pwdata[2:0];
        `IDX_PORT_DIR:   if (pstrb[0]) next_st.port_dir = pwdata[1:0];
        `IDX_PORT_DATA:  if (pstrb[0]) next_st.port_data = pwdata[1:0];
        default: ;
      endcase
    end

    // A new event beats a simultaneous write-one clear
    next_st.status = (st.status & ~clr) | set;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pready    = st.pready;
  assign prdata    = st.prdata;
  assign pslverr   = st.pslverr;
  assign pin_a_out = st.pin_out[0];
  assign pin_b_out = st.pin_out[1];
  assign pin_a_oe  = st.port_dir[0];
  assign pin_b_oe  = st.port_dir[1];
  assign irq       = st.irq;

  logic immediate_set_a;
  assign immediate_set_a = (cls == cls_normal || cls == cls_ctc)
                           && out_mode_chan_a == 2'h3 && match_a;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_COUNT_ONLY_ON_TICK: assert property (
    !tick && !cnt_wr |=> $stable(st.cnt))
    else $error("counter moved without a tick");
  AST_PFC_OVF_AT_BOTTOM: assert property (
    cls == cls_pfc && at_bottom |=> st.status[`ST_OVF] && !st.count_down)
    else $error("overflow flag missing at BOTTOM in mode 8/9");
  AST_PIN_FOLLOWS_WAVE: assert property (
    ovr_a |=> pin_a_out == $past(st.wave[0]))
    else $error("pin A not driven from wave output");
  AST_NONPWM_SET: assert property (
    !st.block_match && immediate_set_a |=> st.wave[0])
    else $error("non-PWM set on match failed");
  AST_FAST_BOTTOM_SET: assert property (
    cls == cls_fast && out_mode_chan_a == 2'h2 && at_bottom && !match_a
    |=> st.wave[0])
    else $error("fast PWM did not set at BOTTOM");
  AST_PWM_TOGGLE_B_OFF: assert property (
    cls != cls_normal && cls != cls_ctc && out_mode_chan_b == `COM_TOGGLE
    |-> !ovr_b ##1 !ovr_b || out_mode_chan_b != `COM_TOGGLE)
    else $error("channel B connected in reserved toggle setting");
  AST_FAST_TOP_IGNORE: assert property (
    cls == cls_fast && out_mode_chan_a[1] && st.cmp_a == top && at_top
    && !at_bottom |=> $stable(st.wave[0]))
    else $error("fast PWM acted on a TOP match");
  AST_DUAL_DOWN_SET: assert property (
    (cls == cls_pc || cls == cls_pfc) && out_mode_chan_a == 2'h2
    && match_a && st.count_down |=> st.wave[0])
    else $error("dual-slope down match did not set");
  AST_PC_LOAD_AT_TOP: assert property (
    cls == cls_pc && at_top |=> st.cmp_a == $past(st.cmp_a_buf))
    else $error("phase correct compare not loaded at TOP");
  AST_FAST_OVF_AT_TOP: assert property (
    cls == cls_fast && at_top |=> st.status[`ST_OVF] && st.cnt == `BOTTOM)
    else $error("fast PWM overflow or wrap wrong at TOP");
  AST_CTC_CLEAR: assert property (
    waveform_mode_select == `MODE_CTC_A && at_top && !cnt_wr
    |=> st.cnt == `BOTTOM)
    else $error("clear on match did not clear counter");
  AST_STOPPED: assert property (
    st.ctrl_b[`CS_HI:`CS_LO] == `CS_STOP |-> !tick)
    else $error("tick while stopped");
  AST_IRQ_LEVEL: assert property (
    (st.status & st.mask) != 3'h0 |-> irq)
    else $error("interrupt low with unmasked flag");

  COV_FAST_BOTTOM: cover property (cls == cls_fast && at_bottom);
  COV_DUAL_TURN: cover property (
    cls == cls_pc && at_top ##[1:1000] cls == cls_pc && at_bottom);
  COV_IRQ_RAISE: cover property (!irq ##1 irq);
  COV_APB_WRITE: cover property (wr && idx == `IDX_CTRL_A);
endmodule : timer16_waveform_mode_control

//--- tb/test_timer16_waveform_mode_control.sv
// Self-checking bench for the 16-bit timer waveform mode control
`timescale 1ns/10ps
`include "timer16_map.svh"
module test_timer16_waveform_mode_control;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_tick_pin;
  logic        pin_a_out;
  logic        pin_a_oe;
  logic        pin_b_out;
  logic        pin_b_oe;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic        pa;
  int          bad_count;
  int          checked;

  timer16_waveform_mode_control u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_tick_pin(ext_tick_pin), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
    .irq(irq)
  );

  task automatic finish_test;
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    pa  = pin_a_out;
    chk(n, 2);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setup(input logic [3:0] m, input logic [1:0] ca,
                       input logic [2:0] cs);
    apb(1, `IDX_CTRL_B, 32'h0);
    apb(1, `IDX_COUNTER, 32'h0);
    apb(1, `IDX_CTRL_A, {24'h0, ca, 4'h0, m[1:0]});
    apb(1, `IDX_CTRL_B, {24'h0, 3'h0, m[3:2], cs});
  endtask : setup

  task automatic t_regs;
    apb(0, `IDX_CTRL_A, 0); chk(rd, 32'h0);
    apb(0, `IDX_CTRL_B, 0); chk(rd, 32'h0);
    apb(1, `IDX_CTRL_A, 32'hFF);
    apb(0, `IDX_CTRL_A, 0); chk(rd, 32'hF3);
    apb(1, `IDX_CTRL_B, 32'hFF);
    apb(0, `IDX_CTRL_B, 0); chk(rd, 32'hDF);
    apb(1, `IDX_CTRL_B, 32'h0);
    apb(0, 10'h3FF, 0); chk(err, 1);
    chk(rd, 32'h0);
  endtask : t_regs

  // Level of pin A follows the counter side of compare value 0x80
  task automatic t_pwm(input logic [3:0] m, input logic [1:0] com,
                       input logic inv);
    int c;
    setup(m, com, 3'h1);
    repeat (2200) @(posedge clk);
    for (int i = 0; i < 24; i++) begin
      apb(0, `IDX_COUNTER, 0);
      c = rd[15:0];
      if (c > 5 && c < 'h70) chk(pa, !inv);
      else if (c > 'h90 && c < 'hF0) chk(pa, inv);
      repeat (37) @(posedge clk);
    end
    chk(pin_a_oe, 1);
    chk(pin_b_oe, 1);
  endtask : t_pwm

  task automatic t_toggles(input logic [3:0] m);
    int n;
    logic last;
    setup(m, 2'b01, 3'h1);
    repeat (300) @(posedge clk);
    n = 0;
    last = pin_a_out;
    repeat (1290) begin
      @(negedge clk);
      if (pin_a_out !== last) n++;
      last = pin_a_out;
    end
    chk(n >= 9 && n <= 11, 1);
  endtask : t_toggles

  task automatic t_disc;
    apb(1, `IDX_PORT_DATA, 32'h3);
    setup(5, 2'b01, 3'h1);
    for (int i = 0; i < 10; i++) begin
      repeat (53) @(posedge clk);
      chk(pin_a_out, 1);
    end
    chk(pin_b_out, 1);
    apb(1, `IDX_PORT_DATA, 32'h0);
    repeat (3) @(posedge clk);
    chk(pin_a_out, 0);
    chk(pin_b_out, 0);
  endtask : t_disc

  task automatic t_irq;
    apb(1, `IDX_CTRL_B, 32'h0);
    apb(1, `IDX_CTRL_A, 32'h0);
    // Flags left by earlier scenarios would hide a missing overflow
    apb(1, `IDX_IRQ_STATUS, 32'h7);
    apb(0, `IDX_IRQ_STATUS, 0);
    chk(rd, 32'h0);
    apb(1, `IDX_COUNTER, 32'hFFF0);
    apb(1, `IDX_CTRL_B, 32'h1);
    repeat (40) @(posedge clk);
    apb(0, `IDX_IRQ_STATUS, 0); chk(rd[0], 1);
    chk(irq, 0);
    apb(1, `IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    apb(1, `IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    apb(0, `IDX_IRQ_STATUS, 0); chk(rd[0], 0);
  endtask : t_irq

  // Stopped source holds the count; divide by 8 advances slowly
  task automatic t_tick;
    logic [15:0] c1;
    setup(0, 2'b00, 3'h0);
    repeat (50) @(posedge clk);
    apb(0, `IDX_COUNTER, 0); chk(rd, 32'h0);
    apb(1, `IDX_CTRL_B, 32'h2);
    apb(0, `IDX_COUNTER, 0);
    c1 = rd[15:0];
    repeat (200) @(posedge clk);
    apb(0, `IDX_COUNTER, 0);
    c1 = rd[15:0] - c1;
    chk(c1 >= 24 && c1 <= 27, 1);
  endtask : t_tick

  task automatic t_top;
    apb(1, `IDX_CMP_A, 32'hFF);
    setup(5, 2'b10, 3'h1);
    repeat (600) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      repeat (29) @(posedge clk);
      chk(pin_a_out, 1);
    end
  endtask : t_top

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    rst_b        = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = '0;
    pwdata       = '0;
    pstrb        = 4'hF;
    ext_tick_pin = 1'b0;
    bad_count    = 0;
    checked      = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    apb(1, `IDX_PORT_DIR, 32'h3);
    apb(1, `IDX_CMP_A, 32'h80);
    apb(1, `IDX_CAPTURE, 32'hFF);
    t_pwm(1, 2'b10, 0);
    t_pwm(2, 2'b11, 1);
    t_pwm(3, 2'b10, 0);
    t_pwm(5, 2'b10, 0);
    t_pwm(6, 2'b11, 1);
    t_pwm(7, 2'b10, 0);
    t_pwm(8, 2'b11, 1);
    t_pwm(10, 2'b10, 0);
    t_pwm(14, 2'b10, 0);
    t_toggles(4);
    t_toggles(15);
    apb(1, `IDX_CAPTURE, 32'h80);
    t_toggles(12);
    t_disc();
    t_irq();
    t_tick();
    t_top();
    finish_test();
  end
endmodule : test_timer16_waveform_mode_control
